// *** src/bsc_defs.svh ***
// Constants of the buck switch controller: timing figures and limits
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
// Core clock rate in MHz
`define BSC_CLK_MHZ 125
// Minimum off time in normal operation, ns
`define BSC_MINOFF_NS 15500
// Soft start stage one minimum off time, ns
`define BSC_SS1_NS 60000
// Soft start stage two minimum off time, ns
`define BSC_SS2_NS 30000
// Leading edge blanking interval, ns
`define BSC_LEB_NS 250
// Least times round up to whole clock cycles
`define BSC_MINOFF_CYC ((`BSC_MINOFF_NS * `BSC_CLK_MHZ + 999) / 1000)
`define BSC_SS1_CYC ((`BSC_SS1_NS * `BSC_CLK_MHZ + 999) / 1000)
`define BSC_SS2_CYC ((`BSC_SS2_NS * `BSC_CLK_MHZ + 999) / 1000)
`define BSC_LEB_CYC ((`BSC_LEB_NS * `BSC_CLK_MHZ + 999) / 1000)
// Switching cycles in each soft start stage
`define BSC_SS_STAGE_CYC 128
// Switching cycles for which open loop detection is blanked
`define BSC_OPEN_BLANK_CYC 64
// Overload delay in ms and reference switching frequency in kHz
`define BSC_OLP_MS 170
`define BSC_OLP_REF_KHZ 36
// Overload delay as a count of switching cycles
`define BSC_OLP_CYC (`BSC_OLP_MS * `BSC_OLP_REF_KHZ)
// Maximum peak current limit, mA
`define BSC_IPK_MAX_MA 500
// Peak limit reduction per microsecond of extra off time, mA
`define BSC_IPK_SLOPE_MA 4
// Short circuit current threshold, mA
`define BSC_SCP_MA 800
// Largest load compensation code
`define BSC_COMP_MAX 15
`endif

// *** src/bsc_pkg.sv ***
// Types shared by the buck switch controller
package bsc_pkg;
   // Analog comparator flags, one bit each
   typedef struct packed {
      logic fb_below_ref;   // Feedback below regulation reference
      logic fb_below_olp;   // Feedback below overload threshold
      logic fb_below_open;  // Feedback below open loop threshold
      logic vcc_at_on;      // Supply reached upper threshold
      logic vcc_below_low;  // Supply below lower threshold
      logic vcc_below_rst;  // Supply below restart threshold
      logic temp_hot;       // Junction at thermal trip level
      logic temp_cooled;    // Junction below trip minus hysteresis
   } bsc_sense_t;

   // Fault and sequence status, all levels
   typedef struct packed {
      logic running;        // Switching allowed
      logic soft_start;     // Soft start in progress
      logic overload;       // Overload fault latched
      logic open_loop;      // Open loop fault latched
      logic thermal;        // Thermal shutdown active
      logic short_circuit;  // Short circuit hold active
   } bsc_status_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_CHARGE,
      ST_OFF,
      ST_ON,
      ST_SCP,
      ST_FAULT
   } bsc_state_t;
endpackage : bsc_pkg

// *** src/bsc_ctrl.sv ***
// Buck switch controller: switching sequencer and protection logic
//
// Behaviour
// - start at upper supply, regulator back below lower
// - faults stop switching, discharge until restart threshold
// - switch on when feedback below reference
// - switch off at peak current limit
// - stay off at least minimum off time
// - peak limit drops with excess off time
// - soft start 60us, 30us, normal; 128 cycles
// - soft start ends once output regulated
// - compensation lowers reference, bigger for faster load
// - ignore current comparator during blanking
// - short circuit stops switching, resumes after min off time
// - overload timer runs below threshold, then faults
// - overload delay counted in switching cycles
// - open loop feedback stops switching, restarts
// - open loop ignored first 64 startup cycles
// - thermal stop until cooled by hysteresis
// - thermal discharge to restart, then recharge
`timescale 1ns/1ps
`include "bsc_defs.svh"

module bsc_ctrl #(
   parameter int OLP_CYC = `BSC_OLP_CYC  // Overload delay in switching cycles
) (
   input wire logic clk_sys,               // Core clock, 125 MHz
   input wire logic arst_n,                // Asynchronous reset, active low
   input wire bsc_pkg::bsc_sense_t sense,  // Comparator flags from pins
   input wire logic [9:0] cur_ma,          // Sensed switch current, mA
   output logic gate_on_ff,                // Power switch drive
   output logic hv_reg_en_ff,              // Startup regulator enable
   output logic latch_discharge_current_ff, // Supply discharge enable
   output logic [3:0] load_compensation_ff, // Reference pull-down code
   output logic [9:0] ipk_limit_ff,        // Present peak current limit, mA
   output bsc_pkg::bsc_status_t status_ff  // Sequence and fault status
);

   localparam logic [15:0] MINOFF = 16'(`BSC_MINOFF_CYC);
   localparam logic [15:0] SS1 = 16'(`BSC_SS1_CYC);
   localparam logic [15:0] SS2 = 16'(`BSC_SS2_CYC);
   localparam logic [5:0] LEB = 6'(`BSC_LEB_CYC);
   localparam logic [9:0] SHORT_CIRCUIT_PROTECT = 10'(`BSC_SCP_MA);
   localparam logic [12:0] OLP_N = 13'(OLP_CYC);

   // Peak current limit for a given off time in cycles
   function automatic logic [9:0] ipk_calc(input logic [15:0] off);
      int us;
      int red;
      us = 0;
      if (off > MINOFF) begin
         us = int'(off - MINOFF) / `BSC_CLK_MHZ;
      end
      red = us * `BSC_IPK_SLOPE_MA;
      if (red >= `BSC_IPK_MAX_MA) begin
         return 10'h000;
      end
      return 10'(`BSC_IPK_MAX_MA - red);
   endfunction : ipk_calc

   // Two-stage synchronisers for pin inputs
   bsc_pkg::bsc_sense_t sense_m_ff;   // First stage, read only by second
   bsc_pkg::bsc_sense_t s;            // Synchronised flags
   logic [9:0] cur_m_ff;              // First stage of current code
   logic [9:0] cur_ff;                // Synchronised current code

   // Sequencer state and counters
   bsc_pkg::bsc_state_t state_ff;     // Present state
   bsc_pkg::bsc_state_t nxt_state;    // Next state
   logic [15:0] off_cnt_ff;           // Cycles since switch turn-off
   logic [15:0] prev_off_ff;          // Off time of previous cycle
   logic [5:0] on_cnt_ff;             // Cycles since turn-on, saturating
   logic [1:0] stage_ff;              // Soft start stage, 2 is normal
   logic [7:0] stage_cnt_ff;          // Switching cycles in this stage
   logic [6:0] start_cnt_ff;          // Cycles since start, to 64
   logic [12:0] olp_cnt_ff;           // Overload switching cycles
   logic therm_ff;                    // Thermal shutdown held
   logic [15:0] minoff;               // Active minimum off time
   logic turn_on;                     // Switch turns on this cycle
   logic turn_off;                    // Switch turns off at the limit
   logic short_hit;                   // Short circuit seen
   logic open_hit;                    // Open loop fault seen
   logic olp_hit;                     // Overload delay expired
   logic fault;                       // Any latching fault

   // Synchronise comparator flags and current code
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sense_m_ff <= '0;
         s <= '0;
         cur_m_ff <= 10'h000;
         cur_ff <= 10'h000;
      end else begin
         sense_m_ff <= sense;
         s <= sense_m_ff;
         cur_m_ff <= cur_ma;
         cur_ff <= cur_m_ff;
      end
   end

   // Minimum off time by soft start stage
   always_comb begin
      case (stage_ff)
         2'h0: minoff = SS1;
         2'h1: minoff = SS2;
         default: minoff = MINOFF;
      endcase
   end

   // Switching events and fault decode
   always_comb begin
      // feedback starts cycle, after min off
      turn_on = (state_ff == bsc_pkg::ST_OFF) && (off_cnt_ff >= minoff) && s.fb_below_ref;
      short_hit = (state_ff == bsc_pkg::ST_ON) && (on_cnt_ff >= LEB) && (cur_ff >= SHORT_CIRCUIT_PROTECT);
      turn_off = (state_ff == bsc_pkg::ST_ON) && (on_cnt_ff >= LEB) && !short_hit
         && (cur_ff >= ipk_limit_ff);
      open_hit = s.fb_below_open && (start_cnt_ff >= 7'(`BSC_OPEN_BLANK_CYC));
      olp_hit = (olp_cnt_ff >= OLP_N);
      // Faults count only in the ON, OFF and short circuit hold states
      fault = ((state_ff == bsc_pkg::ST_ON) || (state_ff == bsc_pkg::ST_OFF)
         || (state_ff == bsc_pkg::ST_SCP)) && (open_hit || olp_hit || s.temp_hot);
   end

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         bsc_pkg::ST_CHARGE: begin
            // start at upper threshold, not while hot
            if (s.vcc_at_on && !therm_ff && !s.temp_hot) begin
               nxt_state = bsc_pkg::ST_OFF;
            end
         end
         bsc_pkg::ST_OFF: begin
            if (fault) begin
               nxt_state = bsc_pkg::ST_FAULT;
            end else if (turn_on) begin
               nxt_state = bsc_pkg::ST_ON;
            end
         end
         bsc_pkg::ST_ON: begin
            if (fault) begin
               nxt_state = bsc_pkg::ST_FAULT;
            end else if (short_hit) begin
               nxt_state = bsc_pkg::ST_SCP;
            end else if (turn_off) begin
               nxt_state = bsc_pkg::ST_OFF;
            end
         end
         bsc_pkg::ST_SCP: begin
            if (fault) begin
               nxt_state = bsc_pkg::ST_FAULT;
            end else if (off_cnt_ff >= minoff) begin
               nxt_state = bsc_pkg::ST_OFF;
            end
         end
         bsc_pkg::ST_FAULT: begin
            if (s.vcc_below_rst) begin
               nxt_state = bsc_pkg::ST_CHARGE;
            end
         end
         default: nxt_state = bsc_pkg::ST_CHARGE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= bsc_pkg::ST_CHARGE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Off time and on time counters
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         off_cnt_ff <= 16'h0000;
         on_cnt_ff <= 6'h00;
      end else begin
         if (nxt_state == bsc_pkg::ST_ON) begin
            off_cnt_ff <= 16'h0000;
         end else if (state_ff == bsc_pkg::ST_ON || state_ff == bsc_pkg::ST_CHARGE) begin
            off_cnt_ff <= 16'h0000;
         end else if (off_cnt_ff != 16'hFFFF) begin
            off_cnt_ff <= off_cnt_ff + 16'h0001;
         end
         if (state_ff != bsc_pkg::ST_ON) begin
            on_cnt_ff <= 6'h00;
         end else if (on_cnt_ff < LEB) begin
            on_cnt_ff <= on_cnt_ff + 6'h01;
         end
      end
   end

   // Peak limit taken from the off time that just ended
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ipk_limit_ff <= 10'(`BSC_IPK_MAX_MA);
      end else if (turn_on) begin
         // limit falls with excess off time
         ipk_limit_ff <= ipk_calc(off_cnt_ff);
      end
   end

   // Load compensation tracks shortening off times
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         load_compensation_ff <= 4'h0;
         prev_off_ff <= 16'h0000;
      end else if (state_ff == bsc_pkg::ST_CHARGE) begin
         load_compensation_ff <= 4'h0;
         prev_off_ff <= 16'h0000;
      end else if (turn_on) begin
         prev_off_ff <= off_cnt_ff;
         // step grows with rate of load change
         if (prev_off_ff > off_cnt_ff) begin
            // Sum taken in eight bits so a large step cannot wrap the code
            if (8'(load_compensation_ff) + 8'((prev_off_ff - off_cnt_ff) >> 9) + 8'h01
               >= 8'(`BSC_COMP_MAX)) begin
               load_compensation_ff <= 4'(`BSC_COMP_MAX);
            end else begin
               // Below the ceiling, so the step fits four bits
               load_compensation_ff <= load_compensation_ff
                  + 4'((prev_off_ff - off_cnt_ff) >> 9) + 4'h1;
            end
         end else if (prev_off_ff < off_cnt_ff && load_compensation_ff != 4'h0) begin
            load_compensation_ff <= load_compensation_ff - 4'h1;
         end
      end
   end

   // Soft start stage sequencing
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stage_ff <= 2'h0;
         stage_cnt_ff <= 8'h00;
         start_cnt_ff <= 7'h00;
      end else if (state_ff == bsc_pkg::ST_CHARGE) begin
         stage_ff <= 2'h0;
         stage_cnt_ff <= 8'h00;
         start_cnt_ff <= 7'h00;
      end else begin
         if (state_ff == bsc_pkg::ST_OFF && stage_ff != 2'h2
            && off_cnt_ff >= minoff && !s.fb_below_ref) begin
            stage_ff <= 2'h2;
         end else if (turn_on && stage_ff != 2'h2) begin
            if (stage_cnt_ff == 8'(`BSC_SS_STAGE_CYC - 1)) begin
               stage_ff <= stage_ff + 2'h1;
               stage_cnt_ff <= 8'h00;
            end else begin
               stage_cnt_ff <= stage_cnt_ff + 8'h01;
            end
         end
         if (turn_on && start_cnt_ff < 7'(`BSC_OPEN_BLANK_CYC)) begin
            start_cnt_ff <= start_cnt_ff + 7'h01;
         end
      end
   end

   // Overload timer in switching cycles
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         olp_cnt_ff <= 13'h0000;
      end else if (state_ff == bsc_pkg::ST_CHARGE || !s.fb_below_olp) begin
         olp_cnt_ff <= 13'h0000;
      end else if (turn_on && olp_cnt_ff < OLP_N) begin
         olp_cnt_ff <= olp_cnt_ff + 13'h0001;
      end
   end

   // Thermal shutdown hold
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         therm_ff <= 1'b0;
      end else if (s.temp_hot) begin
         therm_ff <= 1'b1;
      end else if (s.temp_cooled) begin
         therm_ff <= 1'b0;
      end
   end

   // Power switch and supply control outputs
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gate_on_ff <= 1'b0;
         hv_reg_en_ff <= 1'b1;
         latch_discharge_current_ff <= 1'b0;
      end else begin
         gate_on_ff <= (nxt_state == bsc_pkg::ST_ON);
         latch_discharge_current_ff <= (nxt_state == bsc_pkg::ST_FAULT);
         case (nxt_state)
            bsc_pkg::ST_CHARGE: hv_reg_en_ff <= 1'b1;
            bsc_pkg::ST_FAULT: hv_reg_en_ff <= 1'b0;
            default: hv_reg_en_ff <= s.vcc_below_low;
         endcase
      end
   end

   // Status flags
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         status_ff <= '0;
      end else begin
         status_ff.running <= (nxt_state == bsc_pkg::ST_ON) || (nxt_state == bsc_pkg::ST_OFF);
         status_ff.soft_start <= (stage_ff != 2'h2) && (state_ff != bsc_pkg::ST_CHARGE);
         status_ff.short_circuit <= (nxt_state == bsc_pkg::ST_SCP);
         status_ff.thermal <= therm_ff || s.temp_hot;
         if (state_ff == bsc_pkg::ST_CHARGE && nxt_state == bsc_pkg::ST_OFF) begin
            status_ff.overload <= 1'b0;
            status_ff.open_loop <= 1'b0;
         end else if (fault) begin
            status_ff.overload <= status_ff.overload | olp_hit;
            status_ff.open_loop <= status_ff.open_loop | open_hit;
         end
      end
   end

endmodule : bsc_ctrl

// *** dv/bsc_ctrl_sva.sv ***
// Assertion checker on the buck switch controller ports
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_ctrl_sva #(
   parameter int OLP_CYC = 8 // Overload delay, switching cycles
) (
   input wire logic clk_sys, // Core clock
   input wire logic arst_n, // Reset, active low
   input wire bsc_pkg::bsc_sense_t sense, // Comparator flags
   input wire logic [9:0] cur_ma, // Switch current, mA
   input wire logic gate_on_ff, // Switch drive
   input wire logic hv_reg_en_ff, // Startup regulator
   input wire logic latch_discharge_current_ff, // Discharge enable
   input wire logic [3:0] load_compensation_ff, // Compensation code
   input wire logic [9:0] ipk_limit_ff, // Peak limit, mA
   input wire bsc_pkg::bsc_status_t status_ff // Status levels
);
   localparam int MIN_OFF = `BSC_MINOFF_CYC - 2; // Off cycles less edge slack
   localparam int LEB = `BSC_LEB_CYC; // Blanking cycles
   logic [15:0] off_cnt_ff; // Cycles with switch off
   logic [15:0] on_cnt_ff; // Cycles with switch on
   logic fault; // A latching fault is shown
   assign fault = status_ff.overload | status_ff.open_loop | status_ff.thermal;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // Saturating on and off time counters
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         off_cnt_ff <= 16'h0000;
         on_cnt_ff <= 16'h0000;
      end else begin
         off_cnt_ff <= gate_on_ff ? 16'h0000 : off_cnt_ff + {15'h0000, off_cnt_ff != 16'hFFFF};
         on_cnt_ff <= !gate_on_ff ? 16'h0000 : on_cnt_ff + {15'h0000, on_cnt_ff != 16'hFFFF};
      end
   end
   // Step shapes reused below
   sequence s_turn_on;
      $rose(gate_on_ff);
   endsequence
   sequence s_fault_entry;
      $rose(fault);
   endsequence
   a_start_reg_off: assert property (
      $rose(status_ff.running) && !sense.vcc_below_low |-> ##[0:1] !hv_reg_en_ff)
      else $error("regulator left on after start");
   a_fault_drain: assert property (s_fault_entry |-> ##[0:1] latch_discharge_current_ff)
      else $error("no discharge after fault");
   a_fault_no_gate: assert property (fault |-> ##1 !gate_on_ff)
      else $error("switching during fault");
   a_drain_reg_off: assert property (
      latch_discharge_current_ff && $past(latch_discharge_current_ff) |-> !hv_reg_en_ff)
      else $error("regulator on while discharging");
   a_restart_reg: assert property ($fell(latch_discharge_current_ff) |-> hv_reg_en_ff)
      else $error("regulator off after discharge");
   a_on_needs_fb: assert property (
      s_turn_on |-> status_ff.running && $past(sense.fb_below_ref, 3))
      else $error("turn-on without low feedback");
   a_peak_off: assert property (
      gate_on_ff && on_cnt_ff > LEB + 2 && cur_ma >= ipk_limit_ff |-> ##[1:4] !gate_on_ff)
      else $error("switch on past peak limit");
   a_min_off: assert property (s_turn_on |-> off_cnt_ff >= MIN_OFF)
      else $error("off time too short");
   a_ipk_bound: assert property (ipk_limit_ff <= 10'h1F4)
      else $error("peak limit above maximum");
   a_blank_hold: assert property (
      $fell(gate_on_ff) && !latch_discharge_current_ff |-> on_cnt_ff >= LEB)
      else $error("turn-off inside blanking");
   a_scp_stop: assert property ($rose(status_ff.short_circuit) |-> ##[0:1] !gate_on_ff)
      else $error("switching after short circuit");
endmodule : bsc_ctrl_sva
bind bsc_ctrl bsc_ctrl_sva #(.OLP_CYC(OLP_CYC)) u_bsc_sva (.clk_sys(clk_sys), .arst_n(arst_n),
   .sense(sense), .cur_ma(cur_ma), .gate_on_ff(gate_on_ff), .hv_reg_en_ff(hv_reg_en_ff),
   .latch_discharge_current_ff(latch_discharge_current_ff),
   .load_compensation_ff(load_compensation_ff), .ipk_limit_ff(ipk_limit_ff),
   .status_ff(status_ff));

// *** dv/bsc_plant.sv ***
// Power stage model: switch current ramp seen by the sense comparator
`timescale 1ns/1ps
module bsc_plant (
   input wire logic clk_sys, // Core clock
   input wire logic arst_n, // Reset, active low
   input wire logic gate_on, // Switch drive from controller
   input wire logic [9:0] step, // Current rise per cycle, mA
   output logic [9:0] cur_ma // Sensed switch current, mA
);
   // Ramp while on, zero while off, clip at full scale
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cur_ma <= 10'h000;
      end else if (!gate_on) begin
         cur_ma <= 10'h000;
      end else if ({1'b0, cur_ma} + {1'b0, step} > 11'h3FF) begin
         cur_ma <= 10'h3FF;
      end else begin
         cur_ma <= cur_ma + step;
      end
   end
endmodule : bsc_plant

// *** dv/test_bsc_ctrl.sv ***
// Self-checking testbench of the buck switch controller
`timescale 1ns/1ps
module test_bsc_ctrl;
   logic clk_sys = 1'b0; // Core clock
   logic arst_n = 1'b0; // Reset, active low
   bsc_pkg::bsc_sense_t sense = '0; // Comparator flags
   logic [9:0] step = 10'h005; // Plant current slope
   logic [9:0] cur_ma; // Current from plant
   logic gate_on_ff, hv_reg_en_ff, latch_discharge_current_ff; // Drive outputs
   logic [3:0] comp; // Compensation code
   logic [9:0] ipk; // Peak limit
   bsc_pkg::bsc_status_t st; // Status
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0; // Cycles run, for the hang guard
   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;
   bsc_ctrl #(.OLP_CYC(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .sense(sense),
      .cur_ma(cur_ma), .gate_on_ff(gate_on_ff), .hv_reg_en_ff(hv_reg_en_ff),
      .latch_discharge_current_ff(latch_discharge_current_ff),
      .load_compensation_ff(comp), .ipk_limit_ff(ipk), .status_ff(st));
   bsc_plant u_plant (.clk_sys(clk_sys), .arst_n(arst_n), .gate_on(gate_on_ff),
      .step(step), .cur_ma(cur_ma));
   // Step n edges, then settle past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // Selects a watched output
   function automatic logic pick(input int k);
      case (k)
         0: return gate_on_ff;
         1: return st.soft_start;
         2: return st.short_circuit;
         default: return st.overload;
      endcase
   endfunction : pick
   // Bounded wait for a level
   task automatic wait_for(input int k, input logic lvl, input int lim);
      int n;
      n = 0;
      while (pick(k) !== lvl && n < lim) begin
         tick(1);
         n++;
      end
      chk(10'(pick(k)), 10'(lvl), "wait timed out");
   endtask : wait_for
   // n whole switching pulses
   task automatic pulse(input int n);
      repeat (n) begin
         wait_for(0, 1'b1, 6000);
         wait_for(0, 1'b0, 600);
      end
   endtask : pulse
   task automatic t_reset();
      chk(10'(hv_reg_en_ff), 10'h001, "regulator off in reset");
      chk(10'({gate_on_ff, latch_discharge_current_ff}), 10'h000, "drive in reset");
      chk(ipk, 10'h1F4, "peak limit reset");
      arst_n = 1'b1;
      tick(2);
      chk(10'(st), 10'h000, "status after reset");
      $display("test reset done");
   endtask : t_reset
   task automatic t_start();
      sense.vcc_at_on = 1'b1;
      tick(6);
      chk(10'({st.running, st.soft_start, hv_reg_en_ff}), 10'h006, "start");
      sense.vcc_at_on = 1'b0;
      sense.vcc_below_low = 1'b1;
      tick(6);
      chk(10'(hv_reg_en_ff), 10'h001, "regulator not back on");
      sense.vcc_below_low = 1'b0;
      wait_for(1, 1'b0, 9000);
      $display("test start done");
   endtask : t_start
   task automatic t_peak();
      sense.fb_below_ref = 1'b1;
      pulse(1);
      wait_for(0, 1'b1, 3000);
      chk(ipk, 10'h1F4, "limit at minimum off");
      // Off time fell from 7504 to 1938 cycles: step of 1 + (5566 >> 9)
      chk(10'(comp), 10'h00B, "compensation step on shorter off");
      wait_for(0, 1'b0, 600);
      sense.fb_below_ref = 1'b0;
      tick(2623);
      sense.fb_below_ref = 1'b1;
      wait_for(0, 1'b1, 50);
      chk(ipk, 10'h1E0, "limit after long off");
      chk(10'(comp), 10'h00A, "compensation not eased");
      wait_for(0, 1'b0, 600);
      $display("test peak done");
   endtask : t_peak
   task automatic t_scp();
      step = 10'h3FF;
      wait_for(0, 1'b1, 3000);
      tick(20);
      chk(10'(gate_on_ff), 10'h001, "off inside blanking");
      wait_for(2, 1'b1, 100);
      wait_for(0, 1'b0, 10);
      step = 10'h005;
      pulse(1);
      $display("test short done");
   endtask : t_scp
   task automatic t_overload();
      sense.fb_below_olp = 1'b1;
      pulse(4);
      sense.fb_below_olp = 1'b0;
      tick(8);
      sense.fb_below_olp = 1'b1;
      pulse(4);
      chk(10'(st.overload), 10'h000, "timer not cleared");
      wait_for(3, 1'b1, 13000);
      tick(4);
      chk(10'({gate_on_ff, latch_discharge_current_ff, hv_reg_en_ff}), 10'h002,
         "fault");
      sense.vcc_below_rst = 1'b1;
      tick(6);
      chk(10'({latch_discharge_current_ff, hv_reg_en_ff}), 10'h001, "restart");
      sense = '0;
      $display("test overload done");
   endtask : t_overload
   task automatic t_open();
      sense.vcc_at_on = 1'b1;
      tick(6);
      chk(10'({st.running, st.overload}), 10'h002, "restart state");
      sense.vcc_at_on = 1'b0;
      sense.fb_below_open = 1'b1;
      wait_for(1, 1'b0, 9000);
      sense.fb_below_ref = 1'b1;
      pulse(3);
      chk(10'(st.open_loop), 10'h000, "open loop not blanked");
      sense.fb_below_open = 1'b0;
      $display("test open loop done");
   endtask : t_open
   task automatic t_thermal();
      sense.temp_hot = 1'b1;
      tick(6);
      chk(10'({st.thermal, gate_on_ff, latch_discharge_current_ff}), 10'h005,
         "hot");
      sense.temp_hot = 1'b0;
      sense.vcc_below_rst = 1'b1;
      tick(6);
      chk(10'(hv_reg_en_ff), 10'h001, "no recharge");
      sense.vcc_below_rst = 1'b0;
      sense.vcc_at_on = 1'b1;
      tick(6);
      chk(10'(st.running), 10'h000, "start while hot");
      sense.temp_cooled = 1'b1;
      tick(6);
      chk(10'({st.running, st.thermal}), 10'h002, "no start once cool");
      $display("test thermal done");
   endtask : t_thermal
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 80000) begin
         fail_count++;
         $display("[FAIL] %0t run too long", $time);
         complete_run();
      end
   end
   // Main sequence
   initial begin
      tick(4);
      t_reset();
      t_start();
      t_peak();
      t_scp();
      t_overload();
      t_open();
      t_thermal();
      complete_run();
   end
endmodule : test_bsc_ctrl
